// ===== core/pcso_pkg.sv
// Purpose: shared constants for the press cycle status and output block
// Assumes: 10 MHz clock, classic Wishbone register access
// Notes: times are kept in their own units, cycle counts are derived
package pcso_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    // start pulse limits in millisecond ticks, START_MAX_S in seconds, and the width counter size
    localparam int START_MIN_SHORT_MS = 100;
    localparam int START_MIN_LONG_MS = 350;
    localparam int START_MAX_S = 30;
    localparam int START_MAX_MS = START_MAX_S * 1000;
    localparam int PULSE_W = 15;
    // register offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_LIMIT = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_IRQ_STAT = 5'h0C;
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_ERR_EN = 1;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_LONG_PULSE = 4;
    localparam int CTRL_ACK_LO = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0107;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0F1F;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_1388;
    localparam logic [31:0] LIMIT_MASK = 32'h0000_FFFF;
    // restart interlock modes
    localparam logic [1:0] MODE_WITHOUT = 2'h1;
    localparam logic [1:0] MODE_ALWAYS = 2'h2;
    localparam logic [1:0] MODE_AFTER_STOP = 2'h3;
    // interrupt bits
    localparam int IRQ_N = 4;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_UNAUTH = 1;
    localparam int IRQ_BLOCKED = 2;
    localparam int IRQ_CYC_REQ = 3;
    // controller states, one-hot
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } pcso_state_e;
endpackage

// ===== core/pcso_start_check.sv
// Purpose: judges each low-high-low pulse on the start input
// Assumes: tick_i is a one-cycle pulse once per millisecond
// Notes: valid_o pulses one cycle on the falling edge of a good pulse
`timescale 1ns/1ps
`default_nettype none
module pcso_start_check (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic long_min_i,
    output logic valid_o
);
    logic start_prev;
    logic [pcso_pkg::PULSE_W-1:0] width;
    wire logic [pcso_pkg::PULSE_W-1:0] min_width;
    wire logic at_max;
    wire logic fall;
    wire logic good;

    // pulse limits and edge detect
    assign min_width = long_min_i ? pcso_pkg::PULSE_W'(pcso_pkg::START_MIN_LONG_MS)
                                  : pcso_pkg::PULSE_W'(pcso_pkg::START_MIN_SHORT_MS);
    assign at_max = (width > pcso_pkg::PULSE_W'(pcso_pkg::START_MAX_MS));
    assign fall = start_prev & ~start_i;
    assign good = fall & (width >= min_width) & ~at_max;

    // measure high time, saturating just past the maximum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_prev <= 1'b0;
            width <= '0;
            valid_o <= 1'b0;
        end else begin
            start_prev <= start_i;
            valid_o <= good;
            if (!start_i) begin
                width <= '0;
            end else if (tick_i && !at_max) begin
                width <= width + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/pcso_top.sv
// Purpose: cycle request, timeout, intervention and start block outputs of a cyclic press block
// Assumes: all inputs synchronous to clk_i; registers over classic Wishbone
// Notes: release_o is combinational so a low static release drops it at once
// What this block does
// - Cycle request output is high while waiting for a protective field intervention.
// - Cycle timeout rises when a start or cycle sequence exceeds the limit.
// - Unauthorized intervention rises on an intervention when none is permitted.
// - Intervention error acknowledged by cycle edge, cycle count or start, per mode.
// - Start blocked output rises when release drops through static release or cycle.
// - While blocked, no restart; block ends at top dead centre without other start.
// - Error flag, when enabled, follows timeout or unauthorized intervention.
// - Release drops immediately whenever static release is low.
// - Start pulse valid between minimum 100 or 350 ms and 30 s.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pcso_top #(
    parameter int TICK_CYCLES = pcso_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // press side
    input wire logic static_release_i,
    input wire logic protective_cycle_i,
    input wire logic top_dead_centre_i,
    input wire logic start_i,
    input wire logic other_mode_start_i,
    output logic release_o,
    output logic cycle_request_o,
    output logic cycle_timeout_o,
    output logic unauthorized_intervention_o,
    output logic start_blocked_off_top_o,
    output logic error_flag_o,
    output logic irq_o
);
    // ==========================================================
    // registers and bus decode
    // ==========================================================
    logic [31:0] ctrl;
    logic [31:0] limit;
    logic [pcso_pkg::IRQ_N-1:0] irq_stat;
    logic [pcso_pkg::IRQ_N-1:0] irq_mask;
    wire logic bus_req;
    wire logic wr_en;
    wire logic [31:0] lane_mask;
    wire logic [31:0] status_word;
    wire logic [31:0] read_word;
    wire logic [pcso_pkg::IRQ_N-1:0] irq_clear;
    wire logic [pcso_pkg::IRQ_N-1:0] irq_event;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr_en = bus_req & we_i;
    assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign irq_clear = (wr_en && adr_i == pcso_pkg::REG_IRQ_STAT)
                       ? (dat_i[pcso_pkg::IRQ_N-1:0] & lane_mask[pcso_pkg::IRQ_N-1:0]) : '0;

    // configuration fields
    wire logic cfg_enable;
    wire logic cfg_err_en;
    wire logic [1:0] cfg_mode;
    wire logic cfg_long;
    wire logic [3:0] cfg_acks;
    assign cfg_enable = ctrl[pcso_pkg::CTRL_ENABLE];
    assign cfg_err_en = ctrl[pcso_pkg::CTRL_ERR_EN];
    assign cfg_mode = ctrl[pcso_pkg::CTRL_MODE_LO +: 2];
    assign cfg_long = ctrl[pcso_pkg::CTRL_LONG_PULSE];
    assign cfg_acks = ctrl[pcso_pkg::CTRL_ACK_LO +: 4];

    // ==========================================================
    // millisecond tick and start pulse check
    // ==========================================================
    logic [15:0] tick_cnt;
    wire logic tick;
    wire logic start_valid;
    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    // free running divider
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    pcso_start_check u_start (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .start_i(start_i),
        .long_min_i(cfg_long),
        .valid_o(start_valid)
    );

    // ==========================================================
    // press sequencing
    // ==========================================================
    pcso_pkg::pcso_state_e state;
    pcso_pkg::pcso_state_e next_state;
    logic cyc_prev;
    logic top_prev;
    logic [15:0] seq_timer;
    logic [3:0] seen_cycles;
    logic [3:0] ack_cycles;
    wire logic cyc_fall;
    wire logic cyc_rise;
    wire logic top_rise;
    wire logic fault;
    wire logic start_cplt;
    wire logic need_met;
    wire logic [3:0] need_cycles;
    wire logic timeout_set;
    wire logic unauth_set;
    wire logic unauth_ack;
    wire logic blocked_set;
    wire logic blocked_clr;
    wire logic auto_go;
    wire logic next_fault_t;
    wire logic next_fault_u;

    // cycle input: intervention is the low phase, its end the rising edge
    assign cyc_fall = cyc_prev & ~protective_cycle_i;
    assign cyc_rise = ~cyc_prev & protective_cycle_i;
    assign top_rise = ~top_prev & top_dead_centre_i;
    assign fault = cycle_timeout_o | unauthorized_intervention_o;
    assign start_cplt = start_valid & static_release_i & ~start_blocked_off_top_o;
    assign need_cycles = (cfg_acks == 4'h0) ? 4'h1 : cfg_acks;
    assign need_met = cyc_rise && (seen_cycles + 4'h1 >= need_cycles);

    // error causes
    assign timeout_set = (state == pcso_pkg::ST_WAIT) && (limit[15:0] != 16'h0000)
                         && (seq_timer >= limit[15:0]);
    assign unauth_set = (state == pcso_pkg::ST_RUN) && cyc_fall;
    assign unauth_ack = (cfg_mode == pcso_pkg::MODE_WITHOUT) ? cyc_rise
                      : (cfg_mode == pcso_pkg::MODE_AFTER_STOP)
                        ? (cyc_rise && ack_cycles + 4'h1 >= need_cycles)
                      : start_cplt;
    assign blocked_set = (state == pcso_pkg::ST_RUN) && !top_dead_centre_i
                         && (!static_release_i || cyc_fall);
    assign blocked_clr = top_dead_centre_i && !other_mode_start_i;
    assign auto_go = (cfg_mode == pcso_pkg::MODE_WITHOUT) && protective_cycle_i;

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            pcso_pkg::ST_STOP: begin
                if (cfg_enable && !fault && static_release_i && !start_blocked_off_top_o
                    && (start_cplt || auto_go)) begin
                    next_state = pcso_pkg::ST_WAIT;
                end
            end
            pcso_pkg::ST_WAIT: begin
                if (!static_release_i || !cfg_enable || timeout_set) begin
                    next_state = pcso_pkg::ST_STOP;
                end else if (need_met) begin
                    next_state = pcso_pkg::ST_RUN;
                end
            end
            pcso_pkg::ST_RUN: begin
                if (!static_release_i || !cfg_enable || cyc_fall) begin
                    next_state = pcso_pkg::ST_STOP;
                end else if (top_rise) begin
                    next_state = pcso_pkg::ST_WAIT;
                end
            end
            default: next_state = pcso_pkg::ST_STOP;
        endcase
    end

    // state, edges and counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= pcso_pkg::ST_STOP;
            cyc_prev <= 1'b1;
            top_prev <= 1'b0;
            seq_timer <= '0;
            seen_cycles <= '0;
        end else begin
            state <= next_state;
            cyc_prev <= protective_cycle_i;
            top_prev <= top_dead_centre_i;
            if (next_state != pcso_pkg::ST_WAIT || state != pcso_pkg::ST_WAIT) begin
                seq_timer <= '0;
                seen_cycles <= '0;
            end else begin
                if (tick && seq_timer != 16'hFFFF) begin
                    seq_timer <= seq_timer + 16'h0001;
                end
                if (cyc_rise) begin
                    seen_cycles <= seen_cycles + 4'h1;
                end
            end
        end
    end

    // sticky error outputs; a new cause wins over the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_timeout_o <= 1'b0;
            unauthorized_intervention_o <= 1'b0;
            start_blocked_off_top_o <= 1'b0;
            ack_cycles <= '0;
        end else begin
            if (timeout_set) begin
                cycle_timeout_o <= 1'b1;
            end else if (start_valid && static_release_i) begin
                cycle_timeout_o <= 1'b0;
            end
            if (unauth_set) begin
                unauthorized_intervention_o <= 1'b1;
            end else if (unauth_ack) begin
                unauthorized_intervention_o <= 1'b0;
            end
            if (unauth_set || !unauthorized_intervention_o) begin
                ack_cycles <= '0;
            end else if (cyc_rise) begin
                ack_cycles <= ack_cycles + 4'h1;
            end
            if (blocked_set) begin
                start_blocked_off_top_o <= 1'b1;
            end else if (blocked_clr) begin
                start_blocked_off_top_o <= 1'b0;
            end
        end
    end

    // status outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_request_o <= 1'b0;
            error_flag_o <= 1'b0;
        end else begin
            cycle_request_o <= (next_state == pcso_pkg::ST_WAIT);
            error_flag_o <= cfg_err_en && (next_fault_t || next_fault_u);
        end
    end

    assign next_fault_t = timeout_set | (cycle_timeout_o & ~(start_valid & static_release_i));
    assign next_fault_u = unauth_set | (unauthorized_intervention_o & ~unauth_ack);

    // release gated at once by static release and by either error
    assign release_o = static_release_i
                       & ~fault
                       & (state == pcso_pkg::ST_RUN) & ~start_blocked_off_top_o;

    // ==========================================================
    // interrupts
    // ==========================================================
    assign irq_event[pcso_pkg::IRQ_TIMEOUT] = timeout_set & ~cycle_timeout_o;
    assign irq_event[pcso_pkg::IRQ_UNAUTH] = unauth_set & ~unauthorized_intervention_o;
    assign irq_event[pcso_pkg::IRQ_BLOCKED] = blocked_set & ~start_blocked_off_top_o;
    assign irq_event[pcso_pkg::IRQ_CYC_REQ] = (next_state == pcso_pkg::ST_WAIT) & ~cycle_request_o;

    // sticky bits, set wins over write-one-to-clear
    genvar gi;
    generate
        for (gi = 0; gi < pcso_pkg::IRQ_N; gi++) begin : g_irq
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    irq_stat[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_stat[gi] <= 1'b1;
                end else if (irq_clear[gi]) begin
                    irq_stat[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq_o = |(irq_stat & irq_mask);

    // ==========================================================
    // register writes and read path
    // ==========================================================
    assign status_word = {23'h000000, state, error_flag_o, start_blocked_off_top_o,
                          unauthorized_intervention_o, cycle_timeout_o, cycle_request_o, release_o};
    assign read_word = (adr_i == pcso_pkg::REG_CTRL) ? ctrl
                     : (adr_i == pcso_pkg::REG_LIMIT) ? limit
                     : (adr_i == pcso_pkg::REG_STATUS) ? status_word
                     : (adr_i == pcso_pkg::REG_IRQ_STAT) ? {28'h0000000, irq_stat}
                     : (adr_i == pcso_pkg::REG_IRQ_MASK) ? {28'h0000000, irq_mask}
                     : 32'h0000_0000;

    // config writes honour byte lanes; ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= pcso_pkg::CTRL_RESET;
            limit <= pcso_pkg::LIMIT_RESET;
            irq_mask <= '0;
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                dat_o <= read_word;
            end
            if (wr_en && adr_i == pcso_pkg::REG_CTRL) begin
                ctrl <= ((ctrl & ~lane_mask) | (dat_i & lane_mask)) & pcso_pkg::CTRL_MASK;
            end
            if (wr_en && adr_i == pcso_pkg::REG_LIMIT) begin
                limit <= ((limit & ~lane_mask) | (dat_i & lane_mask)) & pcso_pkg::LIMIT_MASK;
            end
            if (wr_en && adr_i == pcso_pkg::REG_IRQ_MASK && sel_i[0]) begin
                irq_mask <= dat_i[pcso_pkg::IRQ_N-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/pcso_chk.sv
// Purpose: port-level assertions for pcso_top
// Assumes: one clock, synchronous active-high reset
// Notes: attached by the bind below the module
`timescale 1ns/1ps
`default_nettype none
module pcso_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic static_release_i,
    input wire logic protective_cycle_i,
    input wire logic top_dead_centre_i,
    input wire logic start_i,
    input wire logic other_mode_start_i,
    input wire logic release_o,
    input wire logic cycle_request_o,
    input wire logic cycle_timeout_o,
    input wire logic unauthorized_intervention_o,
    input wire logic start_blocked_off_top_o,
    input wire logic error_flag_o
);
    // ====================
    // helpers
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire any_err = cycle_timeout_o || unauthorized_intervention_o;
    wire lost = !static_release_i || !protective_cycle_i;
    wire top_ok = top_dead_centre_i && !other_mode_start_i;
    logic start_q;
    logic [3:0] since_fall;
    // cycles since the start input last fell
    always_ff @(posedge clk_i) begin
        start_q <= start_i;
        if (rst_i) begin
            since_fall <= 4'hF;
        end else if (start_q && !start_i) begin
            since_fall <= 4'h0;
        end else if (since_fall != 4'hF) begin
            since_fall <= since_fall + 4'h1;
        end
    end
    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // ====================
    // assertions
    release_static_a: assert property (!static_release_i |-> !release_o)
        else $error("release high while static release low");
    release_error_a: assert property (any_err |-> !release_o)
        else $error("release high while an error stands");
    flag_cause_a: assert property (error_flag_o |-> any_err)
        else $error("error flag without an error");
    unauth_cause_a: assert property ($rose(unauthorized_intervention_o) |-> !$past(protective_cycle_i))
        else $error("intervention error without field low");
    timeout_clear_a: assert property ($fell(cycle_timeout_o) |-> since_fall < 4'h6)
        else $error("timeout cleared without a start");
    timeout_wait_a: assert property ($rose(cycle_timeout_o) |-> $past(cycle_request_o))
        else $error("timeout outside waiting state");
    block_cause_a: assert property ($rose(start_blocked_off_top_o) |-> $past(lost))
        else $error("block without release loss");
    block_clear_a: assert property ($fell(start_blocked_off_top_o) |-> $past(top_ok))
        else $error("block cleared off top");
    block_hold_a: assert property (start_blocked_off_top_o |-> !release_o)
        else $error("release while blocked");
    ack_time_a: assert property (bus_req_s |=> ack_o)
        else $error("bus request not acked next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
endmodule
bind pcso_top pcso_chk chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .static_release_i(static_release_i), .protective_cycle_i(protective_cycle_i),
    .top_dead_centre_i(top_dead_centre_i), .start_i(start_i), .other_mode_start_i(other_mode_start_i),
    .release_o(release_o), .cycle_request_o(cycle_request_o), .cycle_timeout_o(cycle_timeout_o),
    .unauthorized_intervention_o(unauthorized_intervention_o),
    .start_blocked_off_top_o(start_blocked_off_top_o), .error_flag_o(error_flag_o)
);
`default_nettype wire

// ===== sim/pcso_press_model.sv
// Purpose: press and protective device stand-in
// Assumes: tasks are entered just after a rising edge
// Notes: every task returns just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pcso_press_model #(
    parameter int TICKS = 10
) (
    input wire logic clk_i,
    output logic static_release_o,
    output logic protective_cycle_o,
    output logic top_dead_centre_o,
    output logic start_o,
    output logic other_mode_start_o
);
    // ====================
    // idle levels, field free
    initial begin
        static_release_o = 1'b0;
        protective_cycle_o = 1'b1;
        top_dead_centre_o = 1'b0;
        start_o = 1'b0;
        other_mode_start_o = 1'b0;
    end
    // static release, top and other-mode start
    task automatic set_pins(input logic s, input logic t, input logic o);
        static_release_o <= s;
        top_dead_centre_o <= t;
        other_mode_start_o <= o;
        @(posedge clk_i);
    endtask
    // field level held by the caller
    task automatic field(input logic c);
        protective_cycle_o <= c;
        @(posedge clk_i);
    endtask
    // one whole intervention, high-low-high
    task automatic intervene(input int n);
        protective_cycle_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        protective_cycle_o <= 1'b1;
        @(posedge clk_i);
    endtask
    // low-high-low start pulse in milliseconds
    task automatic start_pulse(input int ms);
        start_o <= 1'b1;
        repeat (ms * TICKS) @(posedge clk_i);
        start_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== sim/pcso_top_tb_top.sv
// Purpose: self-checking bench for pcso_top
// Assumes: millisecond tick shortened to 10 cycles
// Notes: press side comes from pcso_press_model
`timescale 1ns/1ps
`default_nettype none
module pcso_top_tb_top;
    // ====================
    // signals
    localparam int TICKS = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i;
    logic [4:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i;
    logic [3:0] lanes = 4'hF;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic ack_o, static_w, cycle_w, top_w, start_w, other_w;
    logic release_o, creq_o, tout_o, unauth_o, blk_o, err_o, irq_o;
    int checks = 0;
    int fail_count = 0;
    pcso_top #(.TICK_CYCLES(TICKS)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .static_release_i(static_w), .protective_cycle_i(cycle_w), .top_dead_centre_i(top_w),
        .start_i(start_w), .other_mode_start_i(other_w), .release_o(release_o),
        .cycle_request_o(creq_o), .cycle_timeout_o(tout_o), .unauthorized_intervention_o(unauth_o),
        .start_blocked_off_top_o(blk_o), .error_flag_o(err_o), .irq_o(irq_o)
    );
    pcso_press_model #(.TICKS(TICKS)) model_u (
        .clk_i(clk_i), .static_release_o(static_w), .protective_cycle_o(cycle_w),
        .top_dead_centre_o(top_w), .start_o(start_w), .other_mode_start_o(other_w)
    );
    // 10 MHz clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ====================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask
    // one classic wishbone cycle, released after ack
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= lanes;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        check("bus ack", 32'h0, n == 50 ? 32'h1 : 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_regs;
        wb(1'b0, pcso_pkg::REG_CTRL, 32'h0, q);
        check("ctrl reset", pcso_pkg::CTRL_RESET, q);
        wb(1'b0, pcso_pkg::REG_LIMIT, 32'h0, q);
        check("limit reset", pcso_pkg::LIMIT_RESET, q);
        lanes = 4'h1;
        wb(1'b1, pcso_pkg::REG_LIMIT, 32'h0000_AA14, q);
        wb(1'b0, pcso_pkg::REG_LIMIT, 32'h0, q);
        check("limit lane 0", 32'h0000_1314, q);
        lanes = 4'h2;
        wb(1'b1, pcso_pkg::REG_LIMIT, 32'h0000_0099, q);
        lanes = 4'hF;
        wb(1'b0, pcso_pkg::REG_LIMIT, 32'h0, q);
        check("limit write", 32'h0000_0014, q);
        wb(1'b0, 5'h14, 32'h0, q);
        check("unmapped read", 32'h0, q);
        $display("test registers done");
    endtask
    task automatic t_run;
        model_u.set_pins(1'b1, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        chk1("cycle request", 1'b1, creq_o);
        model_u.intervene(5);
        repeat (2) @(posedge clk_i);
        chk1("release in run", 1'b1, release_o);
        chk1("request in run", 1'b0, creq_o);
        model_u.set_pins(1'b0, 1'b0, 1'b0);
        chk1("release static low", 1'b0, release_o);
        @(posedge clk_i);
        chk1("blocked by static", 1'b1, blk_o);
        model_u.set_pins(1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clk_i);
        chk1("blocked other start", 1'b1, blk_o);
        chk1("no restart blocked", 1'b0, release_o);
        model_u.set_pins(1'b1, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        chk1("block cleared", 1'b0, blk_o);
        $display("test run done");
    endtask
    task automatic t_unauth;
        model_u.set_pins(1'b1, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        model_u.intervene(5);
        repeat (2) @(posedge clk_i);
        wb(1'b1, pcso_pkg::REG_IRQ_STAT, 32'h0000_000F, q);
        wb(1'b1, pcso_pkg::REG_IRQ_MASK, 32'h0000_0002, q);
        chk1("irq idle", 1'b0, irq_o);
        model_u.field(1'b0);
        @(posedge clk_i);
        chk1("unauthorized", 1'b1, unauth_o);
        chk1("flag on intervention", 1'b1, err_o);
        chk1("release on error", 1'b0, release_o);
        chk1("irq raised", 1'b1, irq_o);
        model_u.field(1'b1);
        repeat (2) @(posedge clk_i);
        chk1("unauth acked", 1'b0, unauth_o);
        chk1("blocked by field", 1'b1, blk_o);
        wb(1'b1, pcso_pkg::REG_IRQ_STAT, 32'h0000_0002, q);
        chk1("irq cleared", 1'b0, irq_o);
        model_u.set_pins(1'b1, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        chk1("block cleared top", 1'b0, blk_o);
        $display("test intervention done");
    endtask
    task automatic t_timeout;
        repeat (260) @(posedge clk_i);
        chk1("timeout", 1'b1, tout_o);
        chk1("flag on timeout", 1'b1, err_o);
        chk1("release on timeout", 1'b0, release_o);
        wb(1'b1, pcso_pkg::REG_CTRL, 32'h0000_0105, q);
        chk1("flag disabled", 1'b0, err_o);
        wb(1'b1, pcso_pkg::REG_CTRL, pcso_pkg::CTRL_RESET, q);
        model_u.intervene(5);
        repeat (2) @(posedge clk_i);
        chk1("timeout kept", 1'b1, tout_o);
        model_u.start_pulse(50);
        repeat (3) @(posedge clk_i);
        chk1("short start", 1'b1, tout_o);
        model_u.start_pulse(120);
        repeat (3) @(posedge clk_i);
        chk1("start clears", 1'b0, tout_o);
        wb(1'b1, pcso_pkg::REG_CTRL, 32'h0000_0117, q);
        repeat (260) @(posedge clk_i);
        model_u.start_pulse(200);
        repeat (3) @(posedge clk_i);
        chk1("below long min", 1'b1, tout_o);
        model_u.start_pulse(400);
        repeat (3) @(posedge clk_i);
        chk1("long start clears", 1'b0, tout_o);
        $display("test timeout done");
    endtask
    // ====================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk_i);
        check("outputs in reset", 32'h0, {24'h0, release_o, creq_o, tout_o, unauth_o, blk_o, err_o, irq_o, ack_o});
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_run();
        t_unauth();
        t_timeout();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
